/* rtl/mcc_regs.vh */
// Register map and field constants for the metering channel config/status bank
`ifndef MCC_REGS_VH
`define MCC_REGS_VH

// Register addresses
`define MCC_ADDR_EVENT_STATUS   16'hE600
`define MCC_ADDR_NOLOAD_STATUS  16'hE608
`define MCC_ADDR_COMP_MODE      16'hE60E
`define MCC_ADDR_CHANNEL_GAIN   16'hE60F
`define MCC_ADDR_SIGN_STATUS    16'hE617
`define MCC_ADDR_CORE_CONFIG    16'hE618

// Reset values
`define MCC_RST_COMP_MODE       16'h01FF
`define MCC_RST_CHANNEL_GAIN    16'h0000
`define MCC_RST_CORE_CONFIG     16'h0000

// Write masks: only documented fields are stored, plus comp_mode reserved bits 8:0
`define MCC_WMASK_COMP_MODE     16'h47FF
`define MCC_WMASK_CHANNEL_GAIN  16'h01FF
`define MCC_WMASK_CORE_CONFIG   16'h0041

// Computation mode fields
`define MCC_CM_GROUP_SEL_BIT    14
`define MCC_CM_PHASE_MSB        10
`define MCC_CM_PHASE_LSB        9
`define MCC_CM_RSVD_MSB         8
`define MCC_PHASE_VOLT_CUR      2'h0
`define MCC_PHASE_CUR_CUR       2'h2
`define MCC_PHASE_NONE          2'h3

// Gain fields
`define MCC_GAIN_DEF_LSB        6
`define MCC_GAIN_VOLT_LSB       3
`define MCC_GAIN_ABC_LSB        0
`define MCC_GAIN_MAX_CODE       3'h4

// Configuration fields
`define MCC_CFG_SOFT_RST_BIT    7
`define MCC_CFG_CAPTURE_BIT     6
`define MCC_CFG_INTEG_BIT       0

// Status field positions
`define MCC_EV_OC_LSB           3
`define MCC_SIGN_REACT_LSB      4
`define MCC_SIGN_ACT_LSB        0

`endif

/* rtl/mcc_gain_decode.v */
// Gain code decoder: three-bit code to one-hot shift of 1 to 16
`timescale 1ns/10ps
`include "mcc_regs.vh"

module mcc_gain_decode (
  input  wire [2:0] code_i,
  output wire [4:0] gain_onehot_o,
  output wire       code_valid_o
);

  // Reserved codes decode to no gain at all; datapath should hold last
  assign code_valid_o  = (code_i <= `MCC_GAIN_MAX_CODE);
  assign gain_onehot_o = code_valid_o ? (5'h01 << code_i) : 5'h00;

endmodule // mcc_gain_decode

/* rtl/mcc_channel_bank.v */
// Metering channel configuration and status register bank
`timescale 1ns/10ps
`include "mcc_regs.vh"

module mcc_channel_bank (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  // Host register port (from the serial host port decoder)
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [15:0] reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  output reg  [15:0] reg_rdata_o,
  output reg         reg_rvalid_o,
  // Measurement status inputs
  input  wire [5:0]  idle_flag_i,
  input  wire [2:0]  active_neg_i,
  input  wire [2:0]  reactive_neg_i,
  input  wire        overcurrent_evt_i,
  input  wire [2:0]  overcurrent_src_i,
  // Configuration outputs
  output reg         group_sel_def_o,
  output reg  [1:0]  phase_measure_mode_o,
  output reg         phase_measure_en_o,
  output reg  [4:0]  gain_group_abc_o,
  output reg  [4:0]  gain_voltage_o,
  output reg  [4:0]  gain_group_def_o,
  output reg         capture_port_enable_o,
  output reg         integrator_enable_o,
  output reg         soft_reset_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  reg  [15:0] comp_mode;
  reg  [15:0] channel_gain;
  reg  [15:0] core_configuration;
  reg  [5:0]  idle_flag;
  reg  [2:0]  active_neg;
  reg  [2:0]  reactive_neg;
  reg  [2:0]  overcurrent_src;
  wire        soft_rst_req;
  wire [14:0] gain_onehot;
  wire [2:0]  gain_valid;
  wire        wr_comp_mode;
  wire        wr_channel_gain;
  wire        wr_core_config;
  reg  [15:0] next_comp_mode;
  reg  [15:0] next_channel_gain;
  reg  [15:0] next_core_configuration;
  reg  [15:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  // One hit per writable register; writes to status addresses simply miss
  assign wr_comp_mode    = reg_wr_i && (reg_addr_i == `MCC_ADDR_COMP_MODE);
  assign wr_channel_gain = reg_wr_i && (reg_addr_i == `MCC_ADDR_CHANNEL_GAIN);
  assign wr_core_config  = reg_wr_i && (reg_addr_i == `MCC_ADDR_CORE_CONFIG);

  // Software reset fires on a config write with the trigger bit set
  assign soft_rst_req = wr_core_config && reg_wdata_i[`MCC_CFG_SOFT_RST_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the writable registers
  // Bits outside the write masks are dropped here and read back as zero; comp_mode reserved bits 8:0 are kept
  always @* begin
    next_comp_mode          = comp_mode;
    next_channel_gain       = channel_gain;
    next_core_configuration = core_configuration;
    if (wr_comp_mode) begin
      // Host is trusted to keep reserved low bits at ones; stored as written
      next_comp_mode = reg_wdata_i & `MCC_WMASK_COMP_MODE;
    end
    if (wr_channel_gain) begin
      next_channel_gain = reg_wdata_i & `MCC_WMASK_CHANNEL_GAIN;
    end
    if (wr_core_config) begin
      // Trigger bit lies outside the mask, so it is never stored
      next_core_configuration = reg_wdata_i & `MCC_WMASK_CORE_CONFIG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  // Soft reset wins over the write that raised it, so the trigger bit never sticks
  always @(posedge clk_sys_i) begin
    if (reset_i || soft_rst_req) begin
      comp_mode          <= `MCC_RST_COMP_MODE;
      channel_gain       <= `MCC_RST_CHANNEL_GAIN;
      core_configuration <= `MCC_RST_CORE_CONFIG;
    end else begin
      comp_mode          <= next_comp_mode;
      channel_gain       <= next_channel_gain;
      core_configuration <= next_core_configuration;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status capture
  // Sign and idle flags track live levels, one register stage behind the pins
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      idle_flag    <= 6'h00;
      active_neg   <= 3'h0;
      reactive_neg <= 3'h0;
    end else begin
      idle_flag    <= idle_flag_i;
      active_neg   <= active_neg_i;
      reactive_neg <= reactive_neg_i;
    end
  end

  // Overcurrent source holds the latest event; there is no clear, so a host
  // always sees the most recent three source bits rather than a sticky history
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      overcurrent_src <= 3'h0;
    end else if (overcurrent_evt_i) begin
      overcurrent_src <= overcurrent_src_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain decoders, one per channel group
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_gain
      mcc_gain_decode u_dec (
        .code_i        (channel_gain[3*g+2:3*g]),
        .gain_onehot_o (gain_onehot[5*g+4:5*g]),
        .code_valid_o  (gain_valid[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Angle mode decode
  // Code 01 is reserved and treated as no measurement, the safe reading
  wire [1:0]  phase_field;
  wire        next_phase_en;
  assign phase_field   = comp_mode[`MCC_CM_PHASE_MSB:`MCC_CM_PHASE_LSB];
  assign next_phase_en = (phase_field == `MCC_PHASE_VOLT_CUR) ||
                         (phase_field == `MCC_PHASE_CUR_CUR);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs, registered
  // Reserved gain codes keep the previous gain rather than zero it
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      group_sel_def_o       <= 1'b0;
      phase_measure_mode_o  <= `MCC_PHASE_VOLT_CUR;
      phase_measure_en_o    <= 1'b1;
      gain_group_abc_o      <= 5'h01;
      gain_voltage_o        <= 5'h01;
      gain_group_def_o      <= 5'h01;
      capture_port_enable_o <= 1'b0;
      integrator_enable_o   <= 1'b0;
      soft_reset_o          <= 1'b0;
    end else begin
      group_sel_def_o      <= comp_mode[`MCC_CM_GROUP_SEL_BIT];
      phase_measure_mode_o <= phase_field;
      phase_measure_en_o   <= next_phase_en;
      if (gain_valid[0]) begin
        gain_group_abc_o <= gain_onehot[4:0];
      end
      if (gain_valid[1]) begin
        gain_voltage_o <= gain_onehot[9:5];
      end
      if (gain_valid[2]) begin
        gain_group_def_o <= gain_onehot[14:10];
      end
      capture_port_enable_o <= core_configuration[`MCC_CFG_CAPTURE_BIT];
      integrator_enable_o   <= core_configuration[`MCC_CFG_INTEG_BIT];
      soft_reset_o          <= soft_rst_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux: unmapped addresses read zero
  // Status words come from the registered copies, never straight from the pins
  always @* begin
    next_rdata = 16'h0000;
    case (reg_addr_i)
      `MCC_ADDR_EVENT_STATUS: begin
        next_rdata = {10'h000, overcurrent_src, 3'h0};
      end
      `MCC_ADDR_NOLOAD_STATUS: begin
        next_rdata = {10'h000, idle_flag};
      end
      `MCC_ADDR_COMP_MODE: begin
        next_rdata = comp_mode;
      end
      `MCC_ADDR_CHANNEL_GAIN: begin
        next_rdata = channel_gain;
      end
      `MCC_ADDR_SIGN_STATUS: begin
        next_rdata = {9'h000, reactive_neg, 1'b0, active_neg};
      end
      `MCC_ADDR_CORE_CONFIG: begin
        next_rdata = core_configuration;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: one-cycle registered answer
  // Data holds between reads, so a slow host may still pick it up late
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

endmodule // mcc_channel_bank

/* tb/mcc_bank_asserts.sv */
// Port assertions for the channel bank
`timescale 1ns/10ps
module mcc_bank_chk (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic        soft_reset_o,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [5:0]  idle_flag_i,
  input wire logic [1:0]  phase_measure_mode_o,
  input wire logic [4:0]  gain_group_abc_o,
  input wire logic [4:0]  gain_voltage_o,
  input wire logic        group_sel_def_o,
  input wire logic        phase_measure_en_o,
  input wire logic        capture_port_enable_o,
  input wire logic        integrator_enable_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Config write strobe; enables land two edges later, through the stored register; soft_reset_o lands one edge later
  wire cfg_wr = reg_wr_i && reg_addr_i == 16'hE618;
  a_soft_reset_pulse: assert property (
    cfg_wr && reg_wdata_i[7] |=> soft_reset_o ##1 !soft_reset_o)
    else $error("soft reset pulse wrong");
  a_capture_follows: assert property (
    cfg_wr && !reg_wdata_i[7] |-> ##2 capture_port_enable_o == $past(reg_wdata_i[6], 2))
    else $error("capture enable wrong");
  a_integ_follows: assert property (
    cfg_wr && !reg_wdata_i[7] |-> ##2 integrator_enable_o == $past(reg_wdata_i[0], 2))
    else $error("integrator enable wrong");
  a_defaults_after_soft_reset_trigger: assert property (
    soft_reset_o |=> !capture_port_enable_o && !integrator_enable_o &&
      gain_voltage_o == 5'h01 && !group_sel_def_o)
    else $error("defaults missing after soft reset");
  a_group_sel: assert property (
    reg_wr_i && reg_addr_i == 16'hE60E |-> ##2 group_sel_def_o == $past(reg_wdata_i[14], 2))
    else $error("group select wrong");
  a_phase_enable: assert property (
    phase_measure_mode_o != 2'h1 |-> phase_measure_en_o == !phase_measure_mode_o[0])
    else $error("angle enable wrong");
  a_gain_abc: assert property (
    reg_wr_i && reg_addr_i == 16'hE60F && reg_wdata_i[2:0] < 3'h5 |-> ##2
      gain_group_abc_o == 5'h01 << $past(reg_wdata_i[2:0], 2))
    else $error("abc gain wrong");
  a_event_low_zero: assert property (
    reg_rd_i && reg_addr_i == 16'hE600 |=> reg_rdata_o[2:0] == 3'h0)
    else $error("reserved event bits set");
  a_idle_read: assert property (
    reg_rd_i && reg_addr_i == 16'hE608 |=> reg_rdata_o == {10'h000, $past(idle_flag_i, 2)})
    else $error("idle flags read wrong");
endmodule // mcc_bank_chk
bind mcc_channel_bank mcc_bank_chk chk_i (.clk_sys_i, .reset_i, .reg_wr_i, .reg_rd_i,
  .soft_reset_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .idle_flag_i, .phase_measure_mode_o,
  .gain_group_abc_o, .gain_voltage_o, .group_sel_def_o, .phase_measure_en_o,
  .capture_port_enable_o, .integrator_enable_o);

/* tb/mcc_host_model.sv */
// Host model driving the register port
`timescale 1ns/10ps
module mcc_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        reg_rvalid_o,
  input  wire logic [15:0] reg_rdata_o,
  output logic             reg_wr_i,
  output logic             reg_rd_i,
  output logic      [15:0] reg_addr_i,
  output logic      [15:0] reg_wdata_i
);
  initial {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 34'h0;
  // Idle write data is scrambled so stale values are never trusted; the address is left as written
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= (a == 16'hE60E) ? (d | 16'h01FF) : d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_wdata_i <= ~d;
  endtask
  // Answer is taken exactly one cycle after the read edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    reg_addr_i <= ~a;
    @(posedge clk_sys_i);
    d = (reg_rvalid_o === 1'b1) ? reg_rdata_o : 16'hXXXX;
  endtask
endmodule // mcc_host_model

/* tb/metering_channel_config_status_tb.sv */
// Self-checking bench for the channel bank
`timescale 1ns/10ps
module metering_channel_config_status_tb;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, overcurrent_evt_i = 1'b0;
  logic [5:0] idle_flag_i = 6'h00;
  logic [2:0] active_neg_i = 3'h0, reactive_neg_i = 3'h0, overcurrent_src_i = 3'h0;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, group_sel_def_o, phase_measure_en_o;
  logic capture_port_enable_o, integrator_enable_o, soft_reset_o;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
  logic [1:0] phase_measure_mode_o;
  logic [4:0] gain_group_abc_o, gain_voltage_o, gain_group_def_o;
  int bad_count = 0, tests_run = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  mcc_channel_bank dut (.clk_sys_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .idle_flag_i, .active_neg_i, .reactive_neg_i,
    .overcurrent_evt_i, .overcurrent_src_i, .group_sel_def_o, .phase_measure_mode_o,
    .phase_measure_en_o, .gain_group_abc_o, .gain_voltage_o, .gain_group_def_o,
    .capture_port_enable_o, .integrator_enable_o, .soft_reset_o);
  mcc_host_model host (.clk_sys_i, .reg_rvalid_o, .reg_rdata_o, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog: tests need under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    bad_count++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rchk(16'hE60E, 16'h01FF);
    rchk(16'hE60F, 16'h0000);
    rchk(16'hE618, 16'h0000);
    $display("test defaults done");
    // Reserved config bits must not stick
    host.wr(16'hE618, 16'hFF41);
    rchk(16'hE618, 16'h0041);
    chk({14'h0, capture_port_enable_o, integrator_enable_o}, 16'h0003);
    // Mode 01 included: reserved, must leave angle measurement off
    for (int m = 0; m < 4; m++) begin
      host.wr(16'hE60E, {1'b1, m[0], 3'h7, m[1:0], 9'h1FF});
      rchk(16'hE60E, {1'b0, m[0], 3'h0, m[1:0], 9'h1FF});
      chk({group_sel_def_o, phase_measure_en_o, phase_measure_mode_o}, {m[0], ~m[0], m[1:0]});
    end
    for (int c = 0; c < 5; c++) begin
      host.wr(16'hE60F, {7'h7F, c[2:0], c[2:0], c[2:0]});
      rchk(16'hE60F, {7'h00, c[2:0], c[2:0], c[2:0]});
      chk({1'b0, gain_group_def_o, gain_voltage_o, gain_group_abc_o},
          {1'b0, {3{5'h01 << c}}});
    end
    // Reserved gain codes leave the gains alone; the read lets outputs settle
    host.wr(16'hE60F, 16'h0177);
    rchk(16'hE60F, 16'h0177);
    chk({1'b0, gain_group_def_o, gain_voltage_o, gain_group_abc_o}, 16'h4210);
    $display("test config done");
    idle_flag_i <= 6'h2A;
    active_neg_i <= 3'h5;
    reactive_neg_i <= 3'h3;
    overcurrent_src_i <= 3'h4;
    overcurrent_evt_i <= 1'b1;
    @(posedge clk_sys_i);
    overcurrent_evt_i <= 1'b0;
    overcurrent_src_i <= 3'h1;
    rchk(16'hE600, 16'h0020);
    rchk(16'hE608, 16'h002A);
    rchk(16'hE617, 16'h0035);
    rchk(16'hE601, 16'h0000);
    $display("test status done");
    host.wr(16'hE618, 16'h00C1);
    rchk(16'hE618, 16'h0000);
    rchk(16'hE60E, 16'h01FF);
    rchk(16'hE60F, 16'h0000);
    chk({14'h0, capture_port_enable_o, integrator_enable_o}, 16'h0000);
    $display("test soft reset done");
    end_of_test;
  end
endmodule // metering_channel_config_status_tb
